// *** design/return_stack_and_pc_unit.sv ***
// Contract
// RULE1: Pointer 0..31, up on push, down on pop
// RULE2: Any reset zeroes the pointer
// RULE3: Software reads and writes the pointer
// RULE4: 31 pushes set the full flag
// RULE5: Full flag cleared only by software or power-on
// RULE6: Fault reset on: 31st push stores pc+2, resets (code stores pc+2 only for a call; a push instruction stores pc)
// RULE7: Fault reset off: pointer sticks at 31
// RULE8: Empty pop loads zero, sets underflow flag
// RULE9: Underflow flag cleared only by software or power-on
// RULE10: Fault reset follows flag setting when enabled
// RULE11: Flags at bits 7,6; bit 5 zero; pointer 4:0
// RULE12: Push instruction increments, writes current pc
// RULE13: Top entry registers read and write entry
// RULE14: Pop instruction decrements the pointer
// RULE15: Interrupt vectoring captures shadow registers
// RULE16: Fast return restores shadow registers
// RULE17: Nested interrupt overwrites shadow values
// RULE18: Fast call loads shadow registers
// RULE19: 21-bit pc, upper bytes via latches
// RULE20: Pc bit 0 is zero, steps by 2 (a return loads a software-written odd top entry as is)
// RULE21: Calls, jumps, branches bypass the latches
// RULE22: Pc low write loads, read copies latches
// RULE23: Push increments first, pop reads first
`timescale 1ns/1ns
module return_stack_and_pc_unit
    import stack_pkg::*;
(
    input wire logic clk,                 // Core clock
    input wire logic nrst,                // Async reset, active low
    input wire logic power_on,            // High for a power-on reset
    input wire logic stack_fault_reset_enable, // Configuration bit
    input wire seq_cmd_type cmd,          // Sequencer command
    input wire core_regs_type core_regs,  // Live status, working, bank
    input wire logic [3:0] addr,          // Register address
    input wire logic [7:0] wdata,         // Write data
    input wire logic wr,                  // Write strobe
    input wire logic rd,                  // Read strobe
    output logic [7:0] rdata,             // Read data, cycle after rd
    output logic [20:0] pc,               // Program counter
    output core_regs_type restore_regs,   // Shadow values
    output logic restore_valid,           // Pulse: load shadow values
    output logic device_reset             // Pulse: stack fault reset
);

    ////////////////////////////////////////////////////////////////////////
    logic [20:0] entry [1:STACK_DEPTH];
    logic [4:0] ptr;
    logic full;
    logic underflow;
    logic [7:0] high_latch;
    logic [4:0] upper_latch;
    core_regs_type shadow;
    logic pending_fault;
    logic [20:0] top_entry;

    wire logic is_push = (cmd.op == op_call) || (cmd.op == op_push);
    wire logic is_pop = (cmd.op == op_return) || (cmd.op == op_pop);
    wire logic at_top = (ptr == PTR_MAX);
    wire logic at_empty = (ptr == PTR_RESET);
    wire logic reg_wr_ptr = wr && (addr == ADDR_STACK_PTR);
    wire logic push_fills = is_push && !pending_fault && (ptr == PTR_MAX - 5'h01);
    wire logic pop_underflows = is_pop && !pending_fault && at_empty;

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr <= PTR_RESET; // RULE2
        end else if (pending_fault) begin
            ptr <= PTR_RESET; // RULE6
        end else if (is_push && !at_top) begin
            ptr <= ptr + 5'h01; // RULE1 RULE7 RULE12 RULE23
        end else if (is_pop && !at_empty) begin
            ptr <= ptr - 5'h01; // RULE1 RULE8 RULE14 RULE23
        end else if (reg_wr_ptr && !is_push && !is_pop) begin
            ptr <= wdata[4:0]; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack storage: written at the incremented slot
    genvar gi;
    generate
        for (gi = 1; gi <= STACK_DEPTH; gi++) begin : g_entry
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    entry[gi] <= PC_RESET;
                end else if (is_push && !at_top && (ptr + 5'h01) == 5'(gi)) begin
                    entry[gi] <= (cmd.op == op_call) ? pc + PC_STEP : pc; // RULE6 RULE12 RULE23
                end else if (wr && !at_empty && ptr == 5'(gi)) begin
                    if (addr == ADDR_TOP_UPPER) begin
                        entry[gi][20:16] <= wdata[4:0]; // RULE13
                    end else if (addr == ADDR_TOP_HIGH) begin
                        entry[gi][15:8] <= wdata; // RULE13
                    end else if (addr == ADDR_TOP_LOW) begin
                        entry[gi][7:0] <= wdata; // RULE13
                    end
                end
            end
        end
    endgenerate

    function automatic logic [20:0] top_value(input logic [4:0] p);
        top_value = (p == PTR_RESET) ? PC_RESET : entry[p];
    endfunction : top_value

    always_comb begin
        top_entry = top_value(ptr);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags, cleared only by software or at power-on so a fault reset keeps them; hardware set beats software clear
    always_ff @(posedge clk) begin
        if (power_on) begin
            full <= 1'b0; // RULE5
            underflow <= 1'b0; // RULE9
        end else begin
            if (push_fills) begin
                full <= 1'b1; // RULE4 RULE7 RULE10
            end else if (reg_wr_ptr && !wdata[FULL_BIT]) begin
                full <= 1'b0; // RULE5
            end
            if (pop_underflows) begin
                underflow <= 1'b1; // RULE8 RULE10
            end else if (reg_wr_ptr && !wdata[UNDERFLOW_BIT]) begin
                underflow <= 1'b0; // RULE9
            end
        end
    end

    // Fault reset is raised at the same edge that sets the flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending_fault <= 1'b0;
        end else begin
            pending_fault <= stack_fault_reset_enable && (push_fills || pop_underflows); // RULE10
        end
    end
    assign device_reset = pending_fault; // RULE6 RULE10

    ////////////////////////////////////////////////////////////////////////
    // Program counter and latches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc <= PC_RESET;
        end else if (pending_fault) begin
            pc <= PC_RESET;
        end else if (cmd.op == op_call || cmd.op == op_jump) begin
            pc <= {cmd.target[20:1], 1'b0}; // RULE21 RULE20
        end else if (cmd.op == op_return) begin
            pc <= top_value(ptr); // RULE8 RULE23
        end else if (wr && addr == ADDR_PC_LOW) begin
            pc <= {upper_latch, high_latch, wdata[7:1], 1'b0}; // RULE22 RULE19
        end else if (cmd.advance) begin
            pc <= pc + PC_STEP; // RULE20
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_latch <= 8'h00;
            upper_latch <= 5'h00;
        end else if (rd && addr == ADDR_PC_LOW) begin
            high_latch <= pc[15:8]; // RULE22
            upper_latch <= pc[20:16]; // RULE22
        end else begin
            if (wr && addr == ADDR_PC_HIGH_LATCH) begin
                high_latch <= wdata;
            end
            if (wr && addr == ADDR_PC_UPPER_LATCH) begin
                upper_latch <= wdata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shadow registers, one deep, not software visible
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shadow <= '0;
        end else if (cmd.interrupt || (cmd.op == op_call && cmd.fast)) begin
            shadow <= core_regs; // RULE15 RULE17 RULE18
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            restore_valid <= 1'b0;
            restore_regs <= '0;
        end else begin
            restore_valid <= (cmd.op == op_return) && cmd.fast; // RULE16
            restore_regs <= shadow; // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == ADDR_STACK_PTR) begin
                rdata <= {full, underflow, 1'b0, ptr}; // RULE11 RULE3
            end else if (addr == ADDR_TOP_UPPER) begin
                rdata <= {3'h0, top_entry[20:16]}; // RULE13
            end else if (addr == ADDR_TOP_HIGH) begin
                rdata <= top_entry[15:8]; // RULE13
            end else if (addr == ADDR_TOP_LOW) begin
                rdata <= top_entry[7:0]; // RULE13
            end else if (addr == ADDR_PC_LOW) begin
                rdata <= pc[7:0]; // RULE19
            end else if (addr == ADDR_PC_HIGH_LATCH) begin
                rdata <= high_latch;
            end else if (addr == ADDR_PC_UPPER_LATCH) begin
                rdata <= {3'h0, upper_latch};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence fill_push;
        push_fills && !power_on;
    endsequence

    sequence fault_restart;
        device_reset ##1 (at_empty && pc == PC_RESET);
    endsequence

    sequence vector_taken;
        cmd.interrupt;
    endsequence

    chk_full_sets: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        fill_push |=> full) else $error("full flag not set");
    chk_full_sticky: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        full && !power_on && !reg_wr_ptr |=> full) else $error("full flag lost");
    chk_fault_reset: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        fill_push and stack_fault_reset_enable |=> device_reset ##1 (ptr == PTR_RESET && full))
        else $error("fault reset wrong");
    chk_ptr_sticks: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        at_top && is_push && !pending_fault |=> at_top) else $error("pointer left 31");
    chk_underflow_pc: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        pop_underflows && cmd.op == op_return && !pending_fault && !power_on
        |=> pc == PC_RESET && underflow && at_empty) else $error("underflow wrong");
    chk_no_fault: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        !stack_fault_reset_enable |=> !device_reset) else $error("reset without enable");
    chk_pc_even: assert property (@(posedge clk) disable iff (!nrst) // RULE20
        !pc[0]) else $error("pc odd");
    chk_fast_restore: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        cmd.op == op_return && cmd.fast |=> restore_valid && restore_regs == $past(shadow))
        else $error("fast return wrong");

    // Pointer movement and software access
    chk_ptr_push: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        is_push && !at_top && !pending_fault |=> ptr == $past(ptr) + 5'h01)
        else $error("pointer did not step up");
    chk_ptr_pop: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        is_pop && !at_empty && !pending_fault |=> ptr == $past(ptr) - 5'h01)
        else $error("pointer did not step down");
    chk_ptr_write: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        reg_wr_ptr && !is_push && !is_pop && !pending_fault |=> ptr == $past(wdata[4:0]))
        else $error("pointer write lost");
    chk_fault_ptr: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        device_reset |=> at_empty)
        else $error("fault reset left pointer");
    chk_status_read: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        rd && addr == ADDR_STACK_PTR |=> rdata[FULL_BIT] == $past(full) && rdata[UNDERFLOW_BIT] == $past(underflow))
        else $error("flag bits misplaced");
    chk_pointer_field: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        rd && addr == ADDR_STACK_PTR |=> !rdata[5] && rdata[4:0] == $past(ptr))
        else $error("pointer field wrong");
    chk_full_keep: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        full && reg_wr_ptr && wdata[FULL_BIT] && !power_on |=> full)
        else $error("full flag lost on write of one");

    // Stack entries
    chk_push_entry: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        cmd.op == op_push && !at_top && !pending_fault |=> top_entry == $past(pc))
        else $error("push stored wrong value");
    chk_call_entry: assert property (@(posedge clk) disable iff (!nrst) // RULE23
        cmd.op == op_call && !at_top && !pending_fault |=> top_entry == $past(pc) + PC_STEP)
        else $error("call stored wrong value");
    chk_push_blocked: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        is_push && at_top && !pending_fault && !wr |=> top_entry == $past(top_entry) && at_top)
        else $error("push at top changed stack");
    chk_return_pc: assert property (@(posedge clk) disable iff (!nrst) // RULE23
        cmd.op == op_return && !pending_fault |=> pc == $past(top_entry))
        else $error("return loaded wrong value");
    chk_pop_keeps_pc: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        cmd.op == op_pop && !pending_fault && !wr && !cmd.advance |=> pc == $past(pc))
        else $error("pop disturbed pc");
    chk_top_write: assert property (@(posedge clk) disable iff (!nrst) // RULE13
        wr && addr == ADDR_TOP_LOW && !at_empty && cmd.op == op_none && !pending_fault
        |=> top_entry[7:0] == $past(wdata))
        else $error("top entry write lost");
    chk_top_read: assert property (@(posedge clk) disable iff (!nrst) // RULE13
        rd && addr == ADDR_TOP_HIGH |=> rdata == $past(top_entry[15:8]))
        else $error("top entry read wrong");

    // Underflow flag
    chk_underflow_sets: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        pop_underflows && !power_on |=> underflow)
        else $error("underflow flag not set");
    chk_pop_at_empty: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        pop_underflows |=> at_empty)
        else $error("pointer left zero");
    chk_underflow_sticky: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        underflow && !power_on && !reg_wr_ptr |=> underflow)
        else $error("underflow flag lost");
    chk_underflow_fault: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        pop_underflows && stack_fault_reset_enable && !power_on |=> underflow ##0 fault_restart)
        else $error("underflow fault reset wrong");

    // Shadow registers
    chk_shadow_capture: assert property (@(posedge clk) disable iff (!nrst) // RULE15
        vector_taken |=> shadow == $past(core_regs))
        else $error("shadow not captured");
    chk_nested_shadow: assert property (@(posedge clk) disable iff (!nrst) // RULE17
        vector_taken ##[1:30] vector_taken |=> shadow == $past(core_regs))
        else $error("nested vector kept old shadow");
    chk_fast_call: assert property (@(posedge clk) disable iff (!nrst) // RULE18
        cmd.op == op_call && cmd.fast |=> shadow == $past(core_regs))
        else $error("fast call did not save");
    chk_no_restore: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        !(cmd.op == op_return && cmd.fast) |=> !restore_valid)
        else $error("restore without fast return");

    // Program counter and latches
    chk_jump_direct: assert property (@(posedge clk) disable iff (!nrst) // RULE21
        (cmd.op == op_jump || cmd.op == op_call) && !pending_fault |=> pc == {$past(cmd.target[20:1]), 1'b0})
        else $error("direct load wrong");
    chk_pc_advance: assert property (@(posedge clk) disable iff (!nrst) // RULE20
        cmd.advance && cmd.op == op_none && !pending_fault && !wr |=> pc == $past(pc) + PC_STEP)
        else $error("pc did not advance by two");
    chk_pc_read: assert property (@(posedge clk) disable iff (!nrst) // RULE19
        rd && addr == ADDR_PC_LOW |=> rdata == $past(pc[7:0]))
        else $error("pc low read wrong");
    chk_latch_copy: assert property (@(posedge clk) disable iff (!nrst) // RULE22
        rd && addr == ADDR_PC_LOW |=> high_latch == $past(pc[15:8]) && upper_latch == $past(pc[20:16]))
        else $error("latches not copied");
    chk_latch_load: assert property (@(posedge clk) disable iff (!nrst) // RULE22
        wr && addr == ADDR_PC_LOW && cmd.op == op_none && !pending_fault
        |=> pc == {$past(upper_latch), $past(high_latch), $past(wdata[7:1]), 1'b0})
        else $error("pc low write did not take latches");

endmodule : return_stack_and_pc_unit

// *** design/stack_pkg.sv ***
package stack_pkg;
    localparam int PC_WIDTH = 21;
    localparam int PTR_WIDTH = 5;
    localparam int STACK_DEPTH = 31;
    localparam logic [4:0] PTR_MAX = 5'h1F;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Register addresses on the plain register port
    localparam logic [3:0] ADDR_STACK_PTR = 4'h0;
    localparam logic [3:0] ADDR_TOP_UPPER = 4'h1;
    localparam logic [3:0] ADDR_TOP_HIGH = 4'h2;
    localparam logic [3:0] ADDR_TOP_LOW = 4'h3;
    localparam logic [3:0] ADDR_PC_LOW = 4'h4;
    localparam logic [3:0] ADDR_PC_HIGH_LATCH = 4'h5;
    localparam logic [3:0] ADDR_PC_UPPER_LATCH = 4'h6;
    // Field positions in the stack pointer register
    localparam int FULL_BIT = 7;
    localparam int UNDERFLOW_BIT = 6;

    typedef enum logic [2:0] {
        op_none,
        op_call,
        op_return,
        op_push,
        op_pop,
        op_jump
    } seq_op_type;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } core_regs_type;

    typedef struct packed {
        seq_op_type op;
        logic fast;
        logic interrupt;
        logic [20:0] target;
        logic advance;
    } seq_cmd_type;
endpackage : stack_pkg

// *** verif/seq_model.sv ***
`timescale 1ns/1ns
module seq_model
    import stack_pkg::*;
(
    input wire logic clk,           // Core clock
    output seq_cmd_type cmd,        // Command to the stack unit
    output core_regs_type core_regs // Live status, working, bank
);
    initial begin
        cmd = '0;
        core_regs = '0;
    end
    // One-cycle command, then idle again
    task automatic issue(input seq_op_type op, input logic fast, input logic intr, input logic [20:0] t,
                         input logic adv);
        @(posedge clk);
        cmd <= '{op: op, fast: fast, interrupt: intr, target: t, advance: adv};
        @(posedge clk);
        cmd <= '0;
    endtask : issue
    task automatic set_regs(input core_regs_type v);
        @(posedge clk);
        core_regs <= v;
    endtask : set_regs
endmodule : seq_model

// *** verif/return_stack_and_pc_unit_tb.sv ***
`timescale 1ns/1ns
module return_stack_and_pc_unit_tb;
    import stack_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic power_on = 1'h1;
    logic fault_en = 1'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [20:0] pc;
    seq_cmd_type cmd;
    core_regs_type core_regs;
    core_regs_type restore_regs;
    logic restore_valid;
    logic device_reset;
    logic rst_seen = 1'h0;
    int errors = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (device_reset === 1'h1) rst_seen <= 1'h1;
    end
    return_stack_and_pc_unit u_dut (.clk(clk), .nrst(nrst), .power_on(power_on),
        .stack_fault_reset_enable(fault_en), .cmd(cmd), .core_regs(core_regs), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pc(pc), .restore_regs(restore_regs), .restore_valid(restore_valid),
        .device_reset(device_reset));
    seq_model u_seq (.clk(clk), .cmd(cmd), .core_regs(core_regs));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg
    task automatic cmp_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        cmp_byte(rdata, exp);
    endtask : cmp_reg
    task automatic cmp_pc(input logic [20:0] exp);
        @(negedge clk);
        cmp_word({3'h0, pc}, {3'h0, exp});
    endtask : cmp_pc
    task automatic op(input seq_op_type o, input logic [20:0] t, input logic f, input logic i);
        u_seq.issue(o, f, i, t, 1'h0);
    endtask : op
    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        power_on <= 1'h0;
        cmp_reg(ADDR_STACK_PTR, 8'h00);
        cmp_pc(PC_RESET);
        wr_reg(ADDR_STACK_PTR, 8'h03);
        cmp_reg(ADDR_STACK_PTR, 8'h03);
        wr_reg(ADDR_STACK_PTR, 8'h00);
        op(op_jump, 21'h001234, 1'h0, 1'h0);
        cmp_pc(21'h001234);
        u_seq.issue(op_none, 1'h0, 1'h0, 21'h000000, 1'h1);
        cmp_pc(21'h001236);
        op(op_call, 21'h000100, 1'h0, 1'h0);
        cmp_pc(21'h000100);
        cmp_reg(ADDR_STACK_PTR, 8'h01);
        cmp_reg(ADDR_TOP_UPPER, 8'h00);
        cmp_reg(ADDR_TOP_HIGH, 8'h12);
        cmp_reg(ADDR_TOP_LOW, 8'h38);
        wr_reg(ADDR_TOP_LOW, 8'h40);
        op(op_return, 21'h000000, 1'h0, 1'h0);
        cmp_pc(21'h001240);
        cmp_reg(ADDR_STACK_PTR, 8'h00);
        op(op_return, 21'h000000, 1'h0, 1'h0);
        cmp_pc(21'h000000);
        op(op_jump, 21'h000200, 1'h0, 1'h0);
        cmp_reg(ADDR_STACK_PTR, 8'h40);
        wr_reg(ADDR_STACK_PTR, 8'h00);
        cmp_reg(ADDR_STACK_PTR, 8'h00);
        op(op_push, 21'h000000, 1'h0, 1'h0);
        op(op_jump, 21'h000300, 1'h0, 1'h0);
        op(op_push, 21'h000000, 1'h0, 1'h0);
        op(op_pop, 21'h000000, 1'h0, 1'h0);
        cmp_reg(ADDR_STACK_PTR, 8'h01);
        cmp_reg(ADDR_TOP_HIGH, 8'h02);
        wr_reg(ADDR_STACK_PTR, 8'h00);
        repeat (31) op(op_push, 21'h000000, 1'h0, 1'h0);
        cmp_reg(ADDR_STACK_PTR, 8'h9F);
        op(op_jump, 21'h000500, 1'h0, 1'h0);
        op(op_push, 21'h000000, 1'h0, 1'h0);
        cmp_reg(ADDR_STACK_PTR, 8'h9F);
        cmp_reg(ADDR_TOP_HIGH, 8'h03);
        cmp_byte({7'h00, rst_seen}, 8'h00);
        wr_reg(ADDR_STACK_PTR, 8'h80);
        cmp_reg(ADDR_STACK_PTR, 8'h80);
        @(posedge clk);
        fault_en <= 1'h1;
        wr_reg(ADDR_STACK_PTR, 8'h1E);
        op(op_push, 21'h000000, 1'h0, 1'h0);
        repeat (3) @(posedge clk);
        cmp_byte({7'h00, rst_seen}, 8'h01);
        cmp_reg(ADDR_STACK_PTR, 8'h80);
        @(posedge clk);
        fault_en <= 1'h0;
        wr_reg(ADDR_STACK_PTR, 8'h00);
        u_seq.set_regs(24'h112233);
        op(op_call, 21'h000008, 1'h0, 1'h1);
        u_seq.set_regs(24'h445566);
        op(op_call, 21'h000018, 1'h0, 1'h1);
        u_seq.set_regs(24'h778899);
        op(op_return, 21'h000000, 1'h1, 1'h0);
        @(negedge clk);
        cmp_word(restore_regs, 24'h445566);
        cmp_byte({7'h00, restore_valid}, 8'h01);
        u_seq.set_regs(24'hAABBCC);
        op(op_call, 21'h000040, 1'h1, 1'h0);
        u_seq.set_regs(24'h000000);
        op(op_return, 21'h000000, 1'h1, 1'h0);
        @(negedge clk);
        cmp_word(restore_regs, 24'hAABBCC);
        wr_reg(ADDR_PC_UPPER_LATCH, 8'h01);
        wr_reg(ADDR_PC_HIGH_LATCH, 8'h23);
        wr_reg(ADDR_PC_LOW, 8'h47);
        cmp_pc(21'h012346);
        op(op_jump, 21'h0ABCDE, 1'h0, 1'h0);
        cmp_reg(ADDR_PC_HIGH_LATCH, 8'h23);
        cmp_reg(ADDR_PC_LOW, 8'hDE);
        cmp_reg(ADDR_PC_HIGH_LATCH, 8'hBC);
        cmp_reg(ADDR_PC_UPPER_LATCH, 8'h0A);
        wr_reg(ADDR_STACK_PTR, 8'h00);
        op(op_return, 21'h000000, 1'h0, 1'h0);
        wr_reg(ADDR_STACK_PTR, 8'h45);
        @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        cmp_reg(ADDR_STACK_PTR, 8'h40);
        @(posedge clk);
        nrst <= 1'h0;
        power_on <= 1'h1;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        power_on <= 1'h0;
        cmp_reg(ADDR_STACK_PTR, 8'h00);
        finish_test();
    end
endmodule : return_stack_and_pc_unit_tb
